// [fdsc_map.svh]
// Purpose: register offsets, field positions and constants for fdsc
// Assumes: 16-bit registers reached by 8-bit index
// Notes: definitions only
`ifndef FDSC_MAP_SVH
`define FDSC_MAP_SVH
`define FDSC_REG_DIV0_INT 8'h00
`define FDSC_REG_DIV0_NUMH 8'h01
`define FDSC_REG_DIV0_NUML 8'h02
`define FDSC_REG_DIV1_INT 8'h03
`define FDSC_REG_SPREAD_CTL 8'h04
`define FDSC_REG_STEP_SIZE 8'h05
`define FDSC_REG_DIV1_NUMH 8'h06
`define FDSC_REG_DIV1_NUML 8'h08
`define FDSC_REG_PRESET_SEL 8'h09
`define FDSC_REG_POWER_CTL 8'h0A
`define FDSC_REG_RES_OFFSET 8'hEE
`define FDSC_INT0_LSB 3
`define FDSC_INT0_MSB 9
`define FDSC_INT1_LSB 9
`define FDSC_INT1_MSB 15
`define FDSC_N0H_LSB 8
`define FDSC_N0H_MSB 15
`define FDSC_N1H_LSB 5
`define FDSC_N1H_MSB 12
`define FDSC_CH0_SEL_BIT 4
`define FDSC_SPREAD_EN_BIT 0
`define FDSC_SPREAD_TYPE_BIT 1
`define FDSC_STEPS_LSB 2
`define FDSC_STEPS_MSB 14
`define FDSC_DEPTH_LSB 9
`define FDSC_DEPTH_MSB 11
`define FDSC_PDN_BIT 1
`define FDSC_AUTOLOAD_DIS_BIT 2
`define FDSC_INT_MIN 7'h06
`define FDSC_INT_MAX 7'h18
`define FDSC_DIG_EXTRA 8'h02
`define FDSC_REG_W 16
`endif

// [fdsc_pkg.sv]
// Purpose: shared types for fdsc
// Assumes: nothing
// Notes: offsets live in fdsc_map.svh
package fdsc_pkg;
	typedef logic [15:0] fdsc_word_t;
	typedef logic [23:0] fdsc_num_t;
	typedef logic [6:0] fdsc_int_t;
	typedef enum logic [2:0] {
		FDSC_SPREAD_CUSTOM = 3'h0,
		FDSC_SPREAD_D010 = 3'h1,
		FDSC_SPREAD_D025 = 3'h2,
		FDSC_SPREAD_D030 = 3'h3,
		FDSC_SPREAD_D050 = 3'h4
	} fdsc_depth_e;
	typedef enum logic [2:0] {
		FDSC_MOD_OFF = 3'h1,
		FDSC_MOD_UP = 3'h2,
		FDSC_MOD_DOWN = 3'h4
	} fdsc_mod_e;
endpackage

// [fdsc_frac_div.sv]
// Purpose: one fractional divider, accumulator picks N or N+1
// Assumes: input clock stands for the resonator-rate tick
// Notes: pulse_o marks each divided period
`timescale 1ns/1ps
`include "fdsc_map.svh"
module fdsc_frac_div (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// control
	input wire logic enable,
	input wire fdsc_pkg::fdsc_int_t div_int,
	input wire fdsc_pkg::fdsc_num_t div_num,
	// output
	output logic pulse_o
);
	import fdsc_pkg::*;
	typedef struct packed {
		logic [24:0] acc;
		logic [7:0] cnt;
		logic pulse;
	} fdsc_fd_s;
	fdsc_fd_s st_r, st_nxt;
	logic [24:0] sum;
	always_comb begin
		st_nxt = st_r;
		sum = {1'b0, st_r.acc[23:0]} + {1'b0, div_num};
		st_nxt.pulse = 1'b0;
		if (!enable) begin
			st_nxt.cnt = 8'h00;
			st_nxt.acc = 25'h0000000;
		end else if (st_r.cnt == 8'h00) begin
			// carry stretches this period by one tick
			st_nxt.pulse = 1'b1;
			st_nxt.acc = sum;
			st_nxt.cnt = {1'b0, div_int} - 8'h01 + {7'h00, sum[24]};
		end else begin
			st_nxt.cnt = st_r.cnt - 8'h01;
		end
	end
	always_ff @(posedge clk) begin
		if (!reset_n) st_r <= '0;
		else st_r <= st_nxt;
	end
	assign pulse_o = st_r.pulse;
endmodule

// [fdsc_ctrl.sv]
// Purpose: registers and control of two fractional dividers with spread
// Assumes: host writes 16-bit registers by index; pins already synced
// Notes: resonator offset comes in from trim storage
//
// What this block does
// - divider 1 is off while no channel selects it
// - only divider 0 is modulated; divider 1 stays plain
// - integer field is 7 bits; host uses 6 to 24
// - numerators are 24 bits; divider 0 split high byte, low word
// - integer and numerator fields sit at fixed register bits
// - channel divider only 2, 4, 6, 8, 10, 20 or 40
// - signed 16-bit resonator offset readable at index 238
// - state clock fed from divider chosen by channel 0 select
// - state clock divides by field plus two
// - spread enable modulates divider 0 outputs, else none
// - type bit: 0 down-spread, 1 center-spread at custom depth only
// - depth select: 0 custom, 1..4 presets, rest reserved
// - custom mode uses step count and step increment
// - power-down bit enters and leaves low power
`timescale 1ns/1ps
`include "fdsc_map.svh"
module fdsc_ctrl #(
	parameter int PRESET_STEPS = 1587,
	parameter logic [15:0] PRESET_INC_D010 = 16'h0010,
	parameter logic [15:0] PRESET_INC_D025 = 16'h0028,
	parameter logic [15:0] PRESET_INC_D030 = 16'h0030,
	parameter logic [15:0] PRESET_INC_D050 = 16'h0050
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// register port
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_idx,
	input wire fdsc_pkg::fdsc_word_t reg_wdata,
	output fdsc_pkg::fdsc_word_t reg_rdata,
	// trim and channel routing
	input wire fdsc_pkg::fdsc_word_t resonator_freq_offset,
	input wire logic [2:0] channel_source_select,
	input wire logic [2:0] channel_divide_code,
	// divider outputs
	output logic frac_divider_0_tick,
	output logic frac_divider_1_tick,
	output logic frac_divider_1_enable,
	output logic state_clock_tick,
	output logic [5:0] channel_divide_value,
	output logic power_down_active,
	output logic spread_active,
	output logic depth_reserved
);
	import fdsc_pkg::*;
	// step counter is 13 bits wide, so longer preset ramps cannot run
	if (PRESET_STEPS < 1 || PRESET_STEPS > 8191) begin : g_bad_steps
		$error("PRESET_STEPS out of range");
	end
	localparam logic [12:0] PSTEPS = 13'(PRESET_STEPS);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		fdsc_word_t r0, r1, r2, r3, r4, r5, r6, r8, r9, r10;
		fdsc_word_t rdata;
		fdsc_num_t mod_off;
		logic [12:0] step;
		fdsc_mod_e mode;
		logic [7:0] dig_cnt;
		logic dig_tick;
		logic [5:0] chdiv;
	} fdsc_st_s;
	fdsc_st_s st_r, st_nxt;

	fdsc_int_t int0, int1, dig_field;
	fdsc_num_t num0, num1, num0_eff, inc_eff;
	logic [12:0] steps_eff;
	logic en0, en1, tick0, tick1, src_tick;
	logic sp_en, sp_center;
	logic [2:0] depth;

	// ------------------------------------------------------------
	// field extraction
	// ------------------------------------------------------------
	always_comb begin
		int0 = st_r.r0[`FDSC_INT0_MSB:`FDSC_INT0_LSB];
		dig_field = st_r.r0[`FDSC_INT0_MSB:`FDSC_INT0_LSB];
		int1 = st_r.r3[`FDSC_INT1_MSB:`FDSC_INT1_LSB];
		num0 = {st_r.r1[`FDSC_N0H_MSB:`FDSC_N0H_LSB], st_r.r2};
		num1 = {st_r.r6[`FDSC_N1H_MSB:`FDSC_N1H_LSB], st_r.r8};
		sp_en = st_r.r4[`FDSC_SPREAD_EN_BIT];
		sp_center = st_r.r4[`FDSC_SPREAD_TYPE_BIT];
		depth = st_r.r9[`FDSC_DEPTH_MSB:`FDSC_DEPTH_LSB];
		depth_reserved = depth > 3'(FDSC_SPREAD_D050);
		// presets are down-spread only
		steps_eff = st_r.r4[`FDSC_STEPS_MSB:`FDSC_STEPS_LSB];
		inc_eff = {8'h00, st_r.r5};
		case (depth)
		3'(FDSC_SPREAD_D010): begin
			steps_eff = PSTEPS;
			inc_eff = {8'h00, PRESET_INC_D010};
		end
		3'(FDSC_SPREAD_D025): begin
			steps_eff = PSTEPS;
			inc_eff = {8'h00, PRESET_INC_D025};
		end
		3'(FDSC_SPREAD_D030): begin
			steps_eff = PSTEPS;
			inc_eff = {8'h00, PRESET_INC_D030};
		end
		3'(FDSC_SPREAD_D050): begin
			steps_eff = PSTEPS;
			inc_eff = {8'h00, PRESET_INC_D050};
		end
		default: begin
		end
		endcase
		power_down_active = st_r.r10[`FDSC_PDN_BIT];
		en0 = !power_down_active;
		// divider 1 idles unless some channel routes from it
		en1 = en0 && (channel_source_select != 3'h0);
		// modulation only ever touches divider 0
		num0_eff = num0 + st_r.mod_off;
	end

	// ------------------------------------------------------------
	// dividers
	// ------------------------------------------------------------
	fdsc_frac_div u_div0 (
		.clk(clk),
		.reset_n(reset_n),
		.enable(en0),
		.div_int(int0),
		.div_num(num0_eff),
		.pulse_o(tick0)
	);
	fdsc_frac_div u_div1 (
		.clk(clk),
		.reset_n(reset_n),
		.enable(en1),
		.div_int(int1),
		.div_num(num1),
		.pulse_o(tick1)
	);
	assign src_tick = st_r.r3[`FDSC_CH0_SEL_BIT] ? tick1 : tick0;

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		// register writes
		if (reg_wr) begin
			if (reg_idx == `FDSC_REG_DIV0_INT) st_nxt.r0 = reg_wdata;
			else if (reg_idx == `FDSC_REG_DIV0_NUMH) st_nxt.r1 = reg_wdata;
			else if (reg_idx == `FDSC_REG_DIV0_NUML) st_nxt.r2 = reg_wdata;
			else if (reg_idx == `FDSC_REG_DIV1_INT) st_nxt.r3 = reg_wdata;
			else if (reg_idx == `FDSC_REG_SPREAD_CTL) st_nxt.r4 = reg_wdata;
			else if (reg_idx == `FDSC_REG_STEP_SIZE) st_nxt.r5 = reg_wdata;
			else if (reg_idx == `FDSC_REG_DIV1_NUMH) st_nxt.r6 = reg_wdata;
			else if (reg_idx == `FDSC_REG_DIV1_NUML) st_nxt.r8 = reg_wdata;
			else if (reg_idx == `FDSC_REG_PRESET_SEL) st_nxt.r9 = reg_wdata;
			else if (reg_idx == `FDSC_REG_POWER_CTL) st_nxt.r10 = reg_wdata;
		end
		// register reads, unmapped reads return zero
		if (reg_rd) begin
			if (reg_idx == `FDSC_REG_DIV0_INT) st_nxt.rdata = st_r.r0;
			else if (reg_idx == `FDSC_REG_DIV0_NUMH) st_nxt.rdata = st_r.r1;
			else if (reg_idx == `FDSC_REG_DIV0_NUML) st_nxt.rdata = st_r.r2;
			else if (reg_idx == `FDSC_REG_DIV1_INT) st_nxt.rdata = st_r.r3;
			else if (reg_idx == `FDSC_REG_SPREAD_CTL) st_nxt.rdata = st_r.r4;
			else if (reg_idx == `FDSC_REG_STEP_SIZE) st_nxt.rdata = st_r.r5;
			else if (reg_idx == `FDSC_REG_DIV1_NUMH) st_nxt.rdata = st_r.r6;
			else if (reg_idx == `FDSC_REG_DIV1_NUML) st_nxt.rdata = st_r.r8;
			else if (reg_idx == `FDSC_REG_PRESET_SEL) st_nxt.rdata = st_r.r9;
			else if (reg_idx == `FDSC_REG_POWER_CTL) st_nxt.rdata = st_r.r10;
			else if (reg_idx == `FDSC_REG_RES_OFFSET)
				st_nxt.rdata = resonator_freq_offset;
			else st_nxt.rdata = 16'h0000;
		end

		// spread modulator: one step per divider 0 period
		if (!sp_en || power_down_active || depth_reserved) begin
			st_nxt.mode = FDSC_MOD_OFF;
			st_nxt.mod_off = 24'h000000;
			st_nxt.step = 13'h0000;
		end else if (tick0) begin
			case (st_r.mode)
			FDSC_MOD_OFF: begin
				// center-spread starts at the middle, down at nominal
				st_nxt.mode = FDSC_MOD_UP;
				st_nxt.step = 13'h0000;
				if (sp_center && depth == 3'(FDSC_SPREAD_CUSTOM))
					st_nxt.mod_off = 24'(inc_eff * {11'h000, steps_eff});
				else st_nxt.mod_off = 24'h000000;
			end
			FDSC_MOD_UP: begin
				// raising the numerator lowers frequency
				st_nxt.mod_off = st_r.mod_off + inc_eff;
				st_nxt.step = st_r.step + 13'h0001;
				if (st_r.step + 13'h0001 >= steps_eff) begin
					st_nxt.mode = FDSC_MOD_DOWN;
					st_nxt.step = 13'h0000;
				end
			end
			FDSC_MOD_DOWN: begin
				st_nxt.mod_off = st_r.mod_off - inc_eff;
				st_nxt.step = st_r.step + 13'h0001;
				if (st_r.step + 13'h0001 >= steps_eff) begin
					st_nxt.mode = FDSC_MOD_UP;
					st_nxt.step = 13'h0000;
				end
			end
			default: st_nxt.mode = FDSC_MOD_OFF;
			endcase
		end

		// state machine clock divider
		st_nxt.dig_tick = 1'b0;
		if (src_tick) begin
			if (st_r.dig_cnt == 8'h00) begin
				st_nxt.dig_tick = 1'b1;
				st_nxt.dig_cnt = 8'({1'b0, dig_field} + `FDSC_DIG_EXTRA
					- 8'h01);
			end else st_nxt.dig_cnt = st_r.dig_cnt - 8'h01;
		end

		// channel divider decode, unlisted codes hold at 2
		case (channel_divide_code)
		3'h0: st_nxt.chdiv = 6'h02;
		3'h1: st_nxt.chdiv = 6'h04;
		3'h2: st_nxt.chdiv = 6'h06;
		3'h3: st_nxt.chdiv = 6'h08;
		3'h4: st_nxt.chdiv = 6'h0A;
		3'h5: st_nxt.chdiv = 6'h14;
		3'h6: st_nxt.chdiv = 6'h28;
		default: st_nxt.chdiv = 6'h02;
		endcase
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			st_r <= '0;
			st_r.mode <= FDSC_MOD_OFF;
			st_r.chdiv <= 6'h02;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign reg_rdata = st_r.rdata;
	assign frac_divider_0_tick = tick0;
	assign frac_divider_1_tick = tick1;
	assign frac_divider_1_enable = en1;
	assign state_clock_tick = st_r.dig_tick;
	assign channel_divide_value = st_r.chdiv;
	assign spread_active = st_r.mode != FDSC_MOD_OFF;
endmodule

// [fdsc_ctrl_properties.sv]
// Purpose: port-level checks for fdsc_ctrl
// Assumes: one clock, synchronous active-low reset
// Notes: attached by the bind at the foot
`timescale 1ns/1ps
`include "fdsc_map.svh"
module fdsc_ctrl_chk (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// register port
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_idx,
	input wire fdsc_pkg::fdsc_word_t reg_wdata,
	input wire fdsc_pkg::fdsc_word_t reg_rdata,
	// trim and routing
	input wire fdsc_pkg::fdsc_word_t resonator_freq_offset,
	input wire logic [2:0] channel_source_select,
	input wire logic [2:0] channel_divide_code,
	// divider outputs
	input wire logic frac_divider_0_tick,
	input wire logic frac_divider_1_tick,
	input wire logic frac_divider_1_enable,
	input wire logic state_clock_tick,
	input wire logic [5:0] channel_divide_value,
	input wire logic power_down_active,
	input wire logic spread_active,
	input wire logic depth_reserved
);
	import fdsc_pkg::*;
	default clocking @(posedge clk);
	endclocking
	default disable iff (!reset_n);
	wire logic pdn_wr = reg_wr && reg_idx == `FDSC_REG_POWER_CTL;
	wire logic sel_wr = reg_wr && reg_idx == `FDSC_REG_PRESET_SEL;
	a_div1_idle: assert property (
		channel_source_select == 3'h0 |-> !frac_divider_1_enable)
		else $error("divider 1 on with no user");
	// power down stops both dividers, selected or not
	a_div1_used: assert property (
		channel_source_select != 3'h0 && !power_down_active
		|-> frac_divider_1_enable)
		else $error("divider 1 off while selected");
	a_div1_quiet: assert property (
		!frac_divider_1_enable [*2] |-> !frac_divider_1_tick)
		else $error("divider 1 ticks while off");
	a_pdn_enter: assert property (
		pdn_wr && reg_wdata[1] |=> power_down_active)
		else $error("power down not entered");
	a_pdn_leave: assert property (
		pdn_wr && !reg_wdata[1] |=> !power_down_active)
		else $error("power down not left");
	a_spread_pdn: assert property (
		power_down_active [*2] |-> !spread_active)
		else $error("spread active in power down");
	a_depth_code: assert property (
		sel_wr |=> depth_reserved == ($past(reg_wdata[11:9]) > 3'h4))
		else $error("reserved depth flag wrong");
	a_trim_read: assert property (
		reg_rd && reg_idx == `FDSC_REG_RES_OFFSET
		|=> reg_rdata == $past(resonator_freq_offset))
		else $error("offset readback wrong");
	a_rdata_hold: assert property (
		!reg_rd |=> $stable(reg_rdata))
		else $error("read data moved without read");
	a_chdiv_twenty: assert property (
		channel_divide_code == 3'h5 |=> channel_divide_value == 6'h14)
		else $error("channel divide not 20");
	c_spread: cover property (spread_active);
	c_state: cover property (state_clock_tick);
	c_div1: cover property (frac_divider_1_tick);
endmodule
bind fdsc_ctrl fdsc_ctrl_chk u_chk (
	.clk(clk),
	.reset_n(reset_n),
	.reg_wr(reg_wr),
	.reg_rd(reg_rd),
	.reg_idx(reg_idx),
	.reg_wdata(reg_wdata),
	.reg_rdata(reg_rdata),
	.resonator_freq_offset(resonator_freq_offset),
	.channel_source_select(channel_source_select),
	.channel_divide_code(channel_divide_code),
	.frac_divider_0_tick(frac_divider_0_tick),
	.frac_divider_1_tick(frac_divider_1_tick),
	.frac_divider_1_enable(frac_divider_1_enable),
	.state_clock_tick(state_clock_tick),
	.channel_divide_value(channel_divide_value),
	.power_down_active(power_down_active),
	.spread_active(spread_active),
	.depth_reserved(depth_reserved)
);

// [fdsc_host_model.sv]
// Purpose: register host driving fdsc_ctrl
// Assumes: one-cycle strobes, read data one edge after the strobe
// Notes: changes go inside power down
`timescale 1ns/1ps
`include "fdsc_map.svh"
module fdsc_host_model (
	// clock
	input wire logic clk,
	// register port
	output logic reg_wr,
	output logic reg_rd,
	output logic [7:0] reg_idx,
	output fdsc_pkg::fdsc_word_t reg_wdata,
	input wire fdsc_pkg::fdsc_word_t reg_rdata
);
	import fdsc_pkg::*;
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_idx = 8'h00;
		reg_wdata = 16'h0000;
	end
	task automatic wr(input logic [7:0] i, input fdsc_word_t d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_idx <= i;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
		// released bus must not keep showing the last word
		reg_wdata <= ~d;
	endtask
	task automatic rd(input logic [7:0] i, output fdsc_word_t d);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_idx <= i;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(posedge clk);
		d = reg_rdata;
	endtask
	// change wrapped in power down, autoload kept off
	task automatic pd_wr(input logic [7:0] i, input fdsc_word_t d);
		wr(`FDSC_REG_POWER_CTL, 16'h0006);
		wr(i, d);
		wr(`FDSC_REG_POWER_CTL, 16'h0004);
	endtask
endmodule

// [fractional_divider_ssc_control_tb_top.sv]
// Purpose: self-checking bench for fdsc_ctrl
// Assumes: host model drives the register port
// Notes: divide fields stay in 6..24 while periods are measured
`timescale 1ns/1ps
`include "fdsc_map.svh"
module fractional_divider_ssc_control_tb_top;
	import fdsc_pkg::*;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic reg_wr, reg_rd;
	logic [7:0] reg_idx;
	fdsc_word_t reg_wdata, reg_rdata, rd_v, n;
	fdsc_word_t trim = 16'hF123;
	logic [2:0] src = 3'h0;
	logic [2:0] code = 3'h0;
	logic t0, t1, en1, ts, power_down_bit, spr, rsv;
	logic [5:0] chv;
	int failures = 0;
	int checked = 0;
	always #12.5 clk = ~clk;
	fdsc_host_model host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_idx(reg_idx), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
	fdsc_ctrl dut (.clk(clk), .reset_n(reset_n), .reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_idx(reg_idx), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.resonator_freq_offset(trim), .channel_source_select(src),
		.channel_divide_code(code), .frac_divider_0_tick(t0),
		.frac_divider_1_tick(t1), .frac_divider_1_enable(en1),
		.state_clock_tick(ts), .channel_divide_value(chv),
		.power_down_active(power_down_bit), .spread_active(spr), .depth_reserved(rsv));
	task automatic final_report();
		if (failures == 0 && checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	function automatic logic tick(input int s);
		return s == 0 ? t0 : (s == 1 ? t1 : ts);
	endfunction
	// cycles from one tick of the chosen source to the next
	task automatic period(input int s, output fdsc_word_t p);
		int k;
		p = 16'h0000;
		for (k = 0; k < 400 && tick(s) !== 1'b1; k++) cyc(1);
		for (k = 0; k < 400; k++) begin
			cyc(1);
			p++;
			if (tick(s) === 1'b1) break;
		end
		if (k == 400) begin
			failures++;
			$display("unexpected at %0t: tick timeout", $time);
			final_report();
		end
	endtask
	task automatic t_regs();
		fdsc_word_t w[4] = '{16'h0E10, 16'h1234, 16'h1FE0, 16'hBEEF};
		logic [7:0] a[4] = '{8'h03, 8'h05, 8'h06, 8'h08};
		for (int i = 0; i < 10; i++) begin
			host.rd(8'(i), rd_v);
			chk(rd_v, 16'h0000);
		end
		host.wr(`FDSC_REG_RES_OFFSET, 16'h0000);
		host.rd(`FDSC_REG_RES_OFFSET, rd_v);
		chk(rd_v, trim);
		for (int i = 0; i < 4; i++) begin
			host.wr(a[i], w[i]);
			host.rd(a[i], rd_v);
			chk(rd_v, w[i]);
		end
		host.pd_wr(`FDSC_REG_DIV1_INT, 16'h0000);
	endtask
	task automatic t_div0();
		host.pd_wr(`FDSC_REG_DIV0_INT, 16'h0030);
		period(0, n);
		chk(n, 16'h0006);
		period(2, n);
		chk(n, 16'h0030);
		host.pd_wr(`FDSC_REG_DIV0_NUMH, 16'h8000);
		period(0, n);
		period(0, rd_v);
		chk(n + rd_v, 16'h000D);
		host.pd_wr(`FDSC_REG_DIV0_NUMH, 16'h0000);
	endtask
	task automatic t_div1();
		@(posedge clk) src <= 3'h4;
		host.pd_wr(`FDSC_REG_DIV1_INT, 16'h0E10);
		// power down is only left at the edge that ends the write
		cyc(1);
		chk(en1, 1'b1);
		period(1, n);
		chk(n, 16'h0007);
		period(2, n);
		// numerator near one: after the first, every period stretches to 8
		chk(n, 16'h0040);
		@(posedge clk) src <= 3'h0;
		host.pd_wr(`FDSC_REG_DIV1_INT, 16'h0E00);
		cyc(1);
		chk(en1, 1'b0);
	endtask
	task automatic t_chdiv();
		logic [5:0] e[8] = '{6'h02, 6'h04, 6'h06, 6'h08,
			6'h0A, 6'h14, 6'h28, 6'h02};
		for (int i = 0; i < 8; i++) begin
			@(posedge clk) code <= 3'(i);
			cyc(2);
			chk(chv, e[i]);
		end
	endtask
	task automatic t_spread();
		host.wr(`FDSC_REG_POWER_CTL, 16'h0006);
		host.wr(`FDSC_REG_STEP_SIZE, 16'h0010);
		// step count first, enable only once the rest is in place
		host.wr(`FDSC_REG_SPREAD_CTL, 16'h0040);
		host.wr(`FDSC_REG_SPREAD_CTL, 16'h0041);
		cyc(2);
		chk({power_down_bit, spr}, 2'b10);
		host.wr(`FDSC_REG_POWER_CTL, 16'h0004);
		cyc(2);
		chk({power_down_bit, spr}, 2'b01);
		for (int d = 1; d < 7; d++) begin
			host.pd_wr(`FDSC_REG_PRESET_SEL, 16'(d << 9));
			cyc(2);
			chk({rsv, spr}, d > 4 ? 2'b10 : 2'b01);
		end
		host.pd_wr(`FDSC_REG_PRESET_SEL, 16'h0000);
		host.pd_wr(`FDSC_REG_SPREAD_CTL, 16'h0043);
		cyc(2);
		chk(spr, 1'b1);
		host.pd_wr(`FDSC_REG_SPREAD_CTL, 16'h0042);
		cyc(2);
		chk(spr, 1'b0);
	endtask
	initial begin
		repeat (8) @(posedge clk);
		reset_n <= 1'b1;
		t_regs();
		t_div0();
		t_div1();
		t_chdiv();
		t_spread();
		final_report();
	end
endmodule
